// [monitor_irq_enable_config.sv]
// Interrupt enable and configuration registers with interrupt pin muxing.
module monitor_irq_enable_config (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_hit,
	input wire logic i_lock,
	input wire logic i_global_irq_en,
	input wire logic i_temp_reading_valid,
	input wire logic [7:0] i_volt_event,
	input wire logic [7:0] i_volt_clear,
	input wire logic [7:0] i_fan_event,
	input wire logic [7:0] i_fan_clear,
	input wire logic i_fan_drive2,
	input wire logic i_speed3_pin,
	output logic [7:0] o_volt_status,
	output logic [7:0] o_fan_status,
	output logic o_speed3_fan_input,
	output logic o_speed3_pin_out,
	output logic o_speed3_pin_oe,
	output logic o_fan_drive2_output,
	output logic o_spinup_reduction_en,
	output logic o_soft_reset,
	output logic o_irq_n
);
	logic [7:0] volt_en_ff;
	logic [7:0] config_ff;
	logic [7:0] fan_en_ff;
	logic soft_reset_ff;
	logic tv_meta_ff;
	logic tv_sync_ff;
	logic sp_meta_ff;
	logic sp_sync_ff;
	logic irq_n_ff;
	logic [7:0] rdata_ff;

	wire logic wr_ok = i_reg_wr & ~i_lock;
	wire logic wr_volt = wr_ok & (i_reg_addr == irq_cfg_pkg::ADDR_VOLT_EN);
	wire logic wr_cfg = wr_ok & (i_reg_addr == irq_cfg_pkg::ADDR_CONFIG);
	wire logic wr_fan = wr_ok & (i_reg_addr == irq_cfg_pkg::ADDR_FAN_EN);
	wire logic start_soft = wr_cfg & i_reg_wdata[irq_cfg_pkg::CFG_SOFT_RESET];
	wire logic [7:0] nxt_cfg = i_reg_wdata & irq_cfg_pkg::CFG_WRITE_MASK;

	// The soft reset bit is held for one cycle in soft_reset_ff; config_ff[7] is always written zero, so it reads back as zero.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			soft_reset_ff <= 1'b0;
		end else begin
			soft_reset_ff <= start_soft;
		end
	end
	assign o_soft_reset = soft_reset_ff;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			volt_en_ff <= irq_cfg_pkg::RST_VOLT_EN;
			config_ff <= irq_cfg_pkg::RST_CONFIG;
			fan_en_ff <= irq_cfg_pkg::RST_FAN_EN;
		end else if (soft_reset_ff) begin
			volt_en_ff <= irq_cfg_pkg::RST_VOLT_EN;
			config_ff <= irq_cfg_pkg::RST_CONFIG;
			fan_en_ff <= irq_cfg_pkg::RST_FAN_EN;
		end else begin
			if (wr_volt) begin
				volt_en_ff <= i_reg_wdata;
			end
			if (wr_cfg) begin
				config_ff <= {1'b0, nxt_cfg[6:0]};
			end
			if (wr_fan) begin
				fan_en_ff <= i_reg_wdata & irq_cfg_pkg::FAN_WRITE_MASK;
			end
		end
	end

	// The temp reading valid and speed3 pins pass two flops before any logic reads them; i_fan_drive2 is used directly.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			tv_meta_ff <= 1'b0;
			tv_sync_ff <= 1'b0;
			sp_meta_ff <= 1'b0;
			sp_sync_ff <= 1'b0;
		end else begin
			tv_meta_ff <= i_temp_reading_valid;
			tv_sync_ff <= tv_meta_ff;
			sp_meta_ff <= i_speed3_pin;
			sp_sync_ff <= sp_meta_ff;
		end
	end

	irq_status_bits #(.WIDTH(8)) u_volt_status (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_soft_reset(soft_reset_ff),
		.i_event(i_volt_event),
		.i_enable(volt_en_ff & irq_cfg_pkg::VOLT_CH_MASK),
		.i_clear(i_volt_clear),
		.o_status(o_volt_status)
	);

	irq_status_bits #(.WIDTH(8)) u_fan_status (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_soft_reset(soft_reset_ff),
		.i_event(i_fan_event),
		.i_enable(fan_en_ff & irq_cfg_pkg::FAN_CH_MASK),
		.i_clear(i_fan_clear),
		.o_status(o_fan_status)
	);

	wire logic volt_irq = volt_en_ff[irq_cfg_pkg::GROUP_BIT] & (|o_volt_status);
	wire logic fan_irq = fan_en_ff[irq_cfg_pkg::GROUP_BIT] & (|o_fan_status);
	wire logic irq_active = i_global_irq_en & (volt_irq | fan_irq);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			irq_n_ff <= 1'b1;
		end else begin
			irq_n_ff <= ~irq_active;
		end
	end
	assign o_irq_n = irq_n_ff;

	wire logic sel_speed3 = config_ff[irq_cfg_pkg::CFG_SPEED3_IRQ];
	wire logic sel_drive2 = config_ff[irq_cfg_pkg::CFG_DRIVE2_IRQ];
	// Open-drain: the pin is driven only while the interrupt is asserted low.
	assign o_speed3_pin_out = 1'b0;
	assign o_speed3_pin_oe = sel_speed3 & ~irq_n_ff;
	assign o_speed3_fan_input = sel_speed3 ? 1'b1 : sp_sync_ff;
	assign o_fan_drive2_output = sel_drive2 ? irq_n_ff : i_fan_drive2;
	assign o_spinup_reduction_en = config_ff[irq_cfg_pkg::CFG_SPINUP];

	wire logic [7:0] cfg_view = {config_ff[7:4], tv_sync_ff, config_ff[2:0]};
	wire logic hit = (i_reg_addr == irq_cfg_pkg::ADDR_VOLT_EN) |
		(i_reg_addr == irq_cfg_pkg::ADDR_CONFIG) | (i_reg_addr == irq_cfg_pkg::ADDR_FAN_EN);
	wire logic [7:0] rd_mux = (i_reg_addr == irq_cfg_pkg::ADDR_VOLT_EN) ? volt_en_ff :
		(i_reg_addr == irq_cfg_pkg::ADDR_CONFIG) ? cfg_view :
		(i_reg_addr == irq_cfg_pkg::ADDR_FAN_EN) ? fan_en_ff : 8'h00;
	assign o_reg_hit = hit;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= rd_mux;
		end
	end
	assign o_reg_rdata = rdata_ff;
endmodule

// [irq_cfg_pkg.sv]
// Package with register offsets, field positions, reset values and write and channel masks.
package irq_cfg_pkg;
	localparam logic [7:0] ADDR_VOLT_EN = 8'h7E;
	localparam logic [7:0] ADDR_CONFIG = 8'h7F;
	localparam logic [7:0] ADDR_FAN_EN = 8'h80;
	localparam logic [7:0] RST_VOLT_EN = 8'hEC;
	localparam logic [7:0] RST_CONFIG = 8'h10;
	localparam logic [7:0] RST_FAN_EN = 8'h1E;
	localparam int GROUP_BIT = 0;
	localparam int CFG_SPEED3_IRQ = 0;
	localparam int CFG_DRIVE2_IRQ = 1;
	localparam int CFG_TEMP_VALID = 3;
	localparam int CFG_SPINUP = 4;
	localparam int CFG_SOFT_RESET = 7;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hF7;
	localparam logic [7:0] VOLT_CH_MASK = 8'hEC;
	localparam logic [7:0] FAN_CH_MASK = 8'h1E;
	localparam logic [7:0] FAN_WRITE_MASK = 8'hFF;
endpackage

// [irq_status_bits.sv]
// Sticky out-of-limit status bits gated by per-channel enables.
module irq_status_bits #(
	parameter int WIDTH = 8
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_soft_reset,
	input wire logic [WIDTH-1:0] i_event,
	input wire logic [WIDTH-1:0] i_enable,
	input wire logic [WIDTH-1:0] i_clear,
	output logic [WIDTH-1:0] o_status
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : gen_bit
			logic status_ff;
			// A set in the cycle of a clear wins, so no event is lost.
			wire logic set_bit = i_event[g] & i_enable[g];
			wire logic nxt_status = set_bit | (status_ff & ~i_clear[g]);
			always_ff @(posedge i_clk or posedge i_reset) begin
				if (i_reset) begin
					status_ff <= 1'b0;
				end else if (i_soft_reset) begin
					status_ff <= 1'b0;
				end else begin
					status_ff <= nxt_status;
				end
			end
			assign o_status[g] = status_ff;
		end
	endgenerate
endmodule

// [host_model.sv]
// Register host on the management side of the block.
module host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_wr = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= (a == 8'h7F) ? (d & 8'h9F) : d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~o_wdata;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		repeat (2) @(posedge i_clk);
		#1 d = i_rdata;
	endtask
endmodule

// [irq_cfg_sva.sv]
// Checker for the enable and configuration block.
module irq_cfg_sva (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_lock,
	input wire logic i_global_irq_en,
	input wire logic [7:0] o_volt_status,
	input wire logic [7:0] o_fan_status,
	input wire logic o_speed3_fan_input,
	input wire logic o_speed3_pin_out,
	input wire logic o_speed3_pin_oe,
	input wire logic o_spinup_reduction_en,
	input wire logic o_soft_reset,
	input wire logic o_irq_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_cfg_wr;
		i_reg_wr && i_reg_addr == 8'h7F && i_reg_wdata[7];
	endsequence
	sequence s_pulse;
		o_soft_reset ##1 !o_soft_reset;
	endsequence
	a_soft_pulse: assert property (s_cfg_wr and !i_lock |=> s_pulse) else $error("bad pulse");
	a_lock_blocks: assert property (s_cfg_wr and i_lock |=> !o_soft_reset) else $error("locked");
	a_soft_default: assert property (o_soft_reset |-> ##[1:2] o_spinup_reduction_en) else $error("sr");
	a_global_off: assert property (!$past(i_global_irq_en) |-> o_irq_n) else $error("global");
	a_irq_release: assert property (o_volt_status == 0 && o_fan_status == 0 |=> o_irq_n) else $error("irq");
	a_pin3_mux: assert property (o_speed3_pin_oe |-> !o_irq_n && !o_speed3_pin_out && o_speed3_fan_input) else $error("pin");
	a_no_channel: assert property ((o_volt_status & 8'h13) == 0 && (o_fan_status & 8'hE1) == 0) else $error("ch");
	a_init_clears: assert property ($past(i_reg_addr) == 8'h7F |-> !o_reg_rdata[7]) else $error("bit7");
endmodule
bind monitor_irq_enable_config irq_cfg_sva i_irq_cfg_sva (.*);

// [monitor_irq_enable_config_test.sv]
// Self-checking bench for the enable and configuration block.
module monitor_irq_enable_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_reset = 1, i_reg_wr, i_lock = 0, i_global_irq_en = 0;
	logic i_temp_reading_valid = 0, i_fan_drive2 = 0, i_speed3_pin = 1;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_volt_status, o_fan_status, d, w;
	logic [7:0] i_volt_event = 0, i_volt_clear = 0, i_fan_event = 0, i_fan_clear = 0;
	logic o_reg_hit, o_speed3_fan_input, o_speed3_pin_out, o_speed3_pin_oe;
	logic o_fan_drive2_output, o_spinup_reduction_en, o_soft_reset, o_irq_n;
	int error_cnt = 0, check_count = 0, cyc = 0;
	monitor_irq_enable_config i_monitor_irq_enable_config (.*);
	host_model i_host_model (.i_clk(i_clk), .i_rdata(o_reg_rdata), .o_wr(i_reg_wr),
		.o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
	initial forever #20 i_clk = ~i_clk;
	function automatic logic [7:0] cfg_exp(logic [7:0] v, logic t);
		return {1'b0, v[6:4], t, v[2:0]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic ev(input logic [7:0] v, input logic [7:0] f, input logic [7:0] c);
		@(posedge i_clk);
		{i_volt_event, i_fan_event, i_volt_clear, i_fan_clear} <= {v, f, c, c};
		@(posedge i_clk);
		{i_volt_event, i_fan_event, i_volt_clear, i_fan_clear} <= 32'h0;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(80));
		repeat (2) @(posedge i_clk);
		i_reset <= 0;
		i_host_model.rd(8'h7E, d); chk(d, 8'hEC);
		i_host_model.rd(8'h7F, d); chk(d, cfg_exp(8'h10, 0));
		i_host_model.rd(8'h80, d); chk(d, 8'h1E);
		chk(8'(o_reg_hit), 8'h01);
		i_host_model.rd(8'h7D, d); chk(d, 8'h00);
		chk(8'(o_reg_hit), 8'h00);
		w = 8'($urandom);
		i_host_model.wr(8'h7E, w | 8'h01);
		i_lock <= 1;
		i_host_model.wr(8'h7E, ~w);
		i_host_model.wr(8'h7F, 8'h80);
		i_host_model.wr(8'h80, 8'h00);
		i_host_model.rd(8'h7E, d); chk(d, w | 8'h01);
		i_host_model.rd(8'h80, d); chk(d, 8'h1E);
		i_lock <= 0;
		i_global_irq_en <= 1;
		ev(8'hFF, 8'h00, 8'h00); chk(o_volt_status, w & 8'hEC);
		chk(8'(o_irq_n), 8'((w & 8'hEC) == 0));
		i_global_irq_en <= 0;
		ev(8'h00, 8'h00, 8'h00); chk(8'(o_irq_n), 8'h01);
		i_global_irq_en <= 1;
		ev(8'h00, 8'h00, 8'hFF); chk(8'(o_irq_n), 8'h01);
		chk(o_volt_status, 8'h00);
		i_host_model.wr(8'h80, 8'h1F);
		i_host_model.wr(8'h7F, 8'h03);
		ev(8'h00, 8'hFF, 8'h00); chk(o_fan_status, 8'h1E);
		chk(8'({o_irq_n, o_fan_drive2_output, o_speed3_pin_oe}), 8'h01);
		chk(8'(o_spinup_reduction_en), 8'h00);
		i_host_model.wr(8'h7F, 8'h80);
		i_host_model.rd(8'h7E, d); chk(d, 8'hEC);
		chk(o_fan_status, 8'h00);
		chk(8'(o_spinup_reduction_en), 8'h01);
		i_temp_reading_valid <= 1;
		i_speed3_pin <= 0;
		i_fan_drive2 <= 1;
		i_host_model.rd(8'h7F, d); chk(d, cfg_exp(8'h10, 1));
		chk(8'({o_speed3_fan_input, o_fan_drive2_output}), 8'h01);
		end_of_test();
	end
endmodule
